// >>> common/drs_defs.vh
`ifndef DRS_DEFS_VH
`define DRS_DEFS_VH

// APB byte offsets of the dedicated registers.
`define DRS_OFF_PC      12'h000
`define DRS_OFF_ACC     12'h004
`define DRS_OFF_TMP     12'h008
`define DRS_OFF_IDX     12'h00c
`define DRS_OFF_EXP     12'h010
`define DRS_OFF_SP      12'h014
`define DRS_OFF_PSW     12'h018
`define DRS_OFF_BANK    12'h01c
`define DRS_OFF_ALUCMD  12'h020
`define DRS_OFF_ALURES  12'h024
`define DRS_OFF_IRQCHK  12'h028

// Condition code byte field positions.
`define DRS_CC_C        0
`define DRS_CC_V        1
`define DRS_CC_Z        2
`define DRS_CC_N        3
`define DRS_CC_IL_LO    4
`define DRS_CC_IL_HI    5
`define DRS_CC_I        6
`define DRS_CC_H        7

// Reset values.
`define DRS_RST_16      16'h0000
`define DRS_RST_PSW     16'h0030
`define DRS_RST_SP      16'h0000
`define DRS_RST_LVL     2'h3

// Operation codes of the flag-update command register.
`define DRS_OP_ADD      3'h0
`define DRS_OP_SUB      3'h1
`define DRS_OP_SHL      3'h2
`define DRS_OP_SHR      3'h3
`define DRS_OP_AND      3'h4
`define DRS_OP_INC      3'h5

// Memory map figures.
`define DRS_MEM_TOP     16'hffff
`define DRS_BANK_BASE   16'h0100
`define DRS_BANK_SHIFT  3

`endif

// >>> rtl/drs_core_regs.v
// Summary of operation
// - Single 64-Kbyte space; I/O lowest, data above, program from top down.
// - Vector tables sit at the topmost addresses of the program area.
// - A 16-bit program counter holds the fetch location.
// - Primary accumulator is 16 bits; byte operations use its low byte.
// - Temporary accumulator is 16-bit partner operand; byte ops use low byte.
// - A 16-bit index register supports indexed address modification.
// - A 16-bit extra pointer holds a memory address.
// - A 16-bit stack pointer locates the stack area.
// - Status word upper byte is bank pointer, lower byte condition code.
// - Half-carry set on carry or borrow between bit 3 and bit 4.
// - Interrupt enable flag permits interrupts when 1; reset clears it.
// - Two-bit level field; request serviced only if level is higher.
// - Negative flag copies the result's most significant bit.
// - Zero flag set when the result equals zero.
// - Overflow flag set on two's-complement overflow.
// - Carry flag from bit 7, or the shifted-out bit for shifts.
// - Banks of eight byte registers, up to 32, chosen by bank pointer.
// - Active bank address derives from the bank pointer.
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "drs_defs.vh"

module drs_core_regs #(
	parameter [15:0] BANK_BASE = `DRS_BANK_BASE
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	output wire [15:0] program_counter,
	output wire [15:0] bank_base_addr,
	output wire        irq_enabled,
	output wire [1:0]  interrupt_level_field
);

	// ==========================================================
	// Register state
	// ==========================================================
	reg [15:0] pc_ff;
	reg [15:0] acc_ff;
	reg [15:0] tmp_ff;
	reg [15:0] idx_ff;
	reg [15:0] exp_ff;
	reg [15:0] sp_ff;
	reg [15:0] psw_ff;
	reg [15:0] alures_ff;
	reg [1:0]  reqlvl_ff;

	wire       wr_en;
	wire       rd_setup;
	wire       mapped;
	wire [7:0] bank_pointer;
	wire [7:0] condition_code_byte;

	assign wr_en   = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready  = 1'b1;
	assign mapped  = (paddr == `DRS_OFF_PC) || (paddr == `DRS_OFF_ACC) || (paddr == `DRS_OFF_TMP) ||
			(paddr == `DRS_OFF_IDX) || (paddr == `DRS_OFF_EXP) || (paddr == `DRS_OFF_SP) ||
			(paddr == `DRS_OFF_PSW) || (paddr == `DRS_OFF_BANK) || (paddr == `DRS_OFF_ALUCMD) ||
			(paddr == `DRS_OFF_ALURES) || (paddr == `DRS_OFF_IRQCHK);
	assign pslverr = psel & penable & ~mapped;

	assign bank_pointer        = psw_ff[15:8];
	assign condition_code_byte = psw_ff[7:0];

	// ==========================================================
	// Arithmetic flag generation
	// ==========================================================
	// The command word carries the opcode in bits 2:0; the operation
	// works on the low bytes and the flags come from the byte result.
	reg [8:0] sum9;
	reg [4:0] nib5;
	reg [7:0] res8;
	reg [15:0] res16;
	reg       c_new;
	reg       h_new;
	reg       v_new;
	reg       upd_h;
	reg       upd_v;
	reg       n_new;
	reg       z_new;
	reg [7:0] a8;
	reg [7:0] t8;

	always @* begin
		a8    = acc_ff[7:0];
		t8    = tmp_ff[7:0];
		sum9  = 9'h000;
		nib5  = 5'h00;
		res8  = 8'h00;
		c_new = psw_ff[`DRS_CC_C];
		h_new = psw_ff[`DRS_CC_H];
		v_new = psw_ff[`DRS_CC_V];
		upd_h = 1'b0;
		upd_v = 1'b0;
		case (pwdata[2:0])
			`DRS_OP_ADD: begin
				sum9  = {1'b0, a8} + {1'b0, t8};
				nib5  = {1'b0, a8[3:0]} + {1'b0, t8[3:0]};
				res8  = sum9[7:0];
				c_new = sum9[8];
				h_new = nib5[4];
				v_new = (a8[7] == t8[7]) && (res8[7] != a8[7]);
				upd_h = 1'b1;
				upd_v = 1'b1;
			end
			`DRS_OP_SUB: begin
				sum9  = {1'b0, a8} - {1'b0, t8};
				nib5  = {1'b0, a8[3:0]} - {1'b0, t8[3:0]};
				res8  = sum9[7:0];
				c_new = sum9[8];
				h_new = nib5[4];
				v_new = (a8[7] != t8[7]) && (res8[7] != a8[7]);
				upd_h = 1'b1;
				upd_v = 1'b1;
			end
			`DRS_OP_SHL: begin
				res8  = {a8[6:0], 1'b0};
				c_new = a8[7];
			end
			`DRS_OP_SHR: begin
				res8  = {1'b0, a8[7:1]};
				c_new = a8[0];
			end
			`DRS_OP_AND: begin
				res8  = a8 & t8;
			end
			default: begin
				res8  = a8 + 8'h01;
			end
		endcase
		n_new = res8[7];
		z_new = (res8 == 8'h00);
		res16 = {acc_ff[15:8], res8};
	end

	// ==========================================================
	// Write decode
	// ==========================================================
	reg        wr_pc;
	reg        wr_acc;
	reg        wr_tmp;
	reg        wr_idx;
	reg        wr_exp;
	reg        wr_sp;
	reg        wr_psw;
	reg        wr_alu;
	reg        wr_lvl;

	always @* begin
		wr_pc  = 1'b0;
		wr_acc = 1'b0;
		wr_tmp = 1'b0;
		wr_idx = 1'b0;
		wr_exp = 1'b0;
		wr_sp  = 1'b0;
		wr_psw = 1'b0;
		wr_alu = 1'b0;
		wr_lvl = 1'b0;
		if (wr_en) begin
			if (paddr == `DRS_OFF_PC) begin
				wr_pc = 1'b1;
			end else if (paddr == `DRS_OFF_ACC) begin
				wr_acc = 1'b1;
			end else if (paddr == `DRS_OFF_TMP) begin
				wr_tmp = 1'b1;
			end else if (paddr == `DRS_OFF_IDX) begin
				wr_idx = 1'b1;
			end else if (paddr == `DRS_OFF_EXP) begin
				wr_exp = 1'b1;
			end else if (paddr == `DRS_OFF_SP) begin
				wr_sp = 1'b1;
			end else if (paddr == `DRS_OFF_PSW) begin
				wr_psw = 1'b1;
			end else if (paddr == `DRS_OFF_ALUCMD) begin
				wr_alu = 1'b1;
			end else if (paddr == `DRS_OFF_IRQCHK) begin
				wr_lvl = 1'b1;
			end
		end
	end

	// ==========================================================
	// Next register values
	// ==========================================================
	reg [15:0] nxt_pc;
	reg [15:0] nxt_acc;
	reg [15:0] nxt_tmp;
	reg [15:0] nxt_idx;
	reg [15:0] nxt_exp;
	reg [15:0] nxt_sp;
	reg [15:0] nxt_psw;
	reg [15:0] nxt_alures;
	reg [1:0]  nxt_reqlvl;

	always @* begin
		nxt_pc     = pc_ff;
		nxt_acc    = acc_ff;
		nxt_tmp    = tmp_ff;
		nxt_idx    = idx_ff;
		nxt_exp    = exp_ff;
		nxt_sp     = sp_ff;
		nxt_psw    = psw_ff;
		nxt_alures = alures_ff;
		nxt_reqlvl = reqlvl_ff;
		if (wr_pc) begin
			nxt_pc = pwdata[15:0];
		end
		if (wr_acc) begin
			nxt_acc = pwdata[15:0];
		end
		if (wr_tmp) begin
			nxt_tmp = pwdata[15:0];
		end
		if (wr_idx) begin
			nxt_idx = pwdata[15:0];
		end
		if (wr_exp) begin
			nxt_exp = pwdata[15:0];
		end
		if (wr_sp) begin
			nxt_sp = pwdata[15:0];
		end
		if (wr_psw) begin
			nxt_psw = pwdata[15:0];
		end
		if (wr_alu) begin
			nxt_alures         = res16;
			nxt_acc            = res16;
			nxt_psw[`DRS_CC_C] = c_new;
			nxt_psw[`DRS_CC_N] = n_new;
			nxt_psw[`DRS_CC_Z] = z_new;
			if (upd_h) begin
				nxt_psw[`DRS_CC_H] = h_new;
			end
			if (upd_v) begin
				nxt_psw[`DRS_CC_V] = v_new;
			end
		end
		if (wr_lvl) begin
			nxt_reqlvl = pwdata[1:0];
		end
	end

	// ==========================================================
	// Register writes
	// ==========================================================
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_ff     <= `DRS_RST_16;
			acc_ff    <= `DRS_RST_16;
			tmp_ff    <= `DRS_RST_16;
			idx_ff    <= `DRS_RST_16;
			exp_ff    <= `DRS_RST_16;
			sp_ff     <= `DRS_RST_SP;
			psw_ff    <= `DRS_RST_PSW;
			alures_ff <= `DRS_RST_16;
			reqlvl_ff <= `DRS_RST_LVL;
		end else begin
			pc_ff     <= nxt_pc;
			acc_ff    <= nxt_acc;
			tmp_ff    <= nxt_tmp;
			idx_ff    <= nxt_idx;
			exp_ff    <= nxt_exp;
			sp_ff     <= nxt_sp;
			psw_ff    <= nxt_psw;
			alures_ff <= nxt_alures;
			reqlvl_ff <= nxt_reqlvl;
		end
	end

	// ==========================================================
	// Derived outputs
	// ==========================================================
	reg        grant;
	reg [15:0] bank_addr;
	reg [15:0] pc_mirror_ff;
	reg [15:0] bank_base_ff;
	reg        irq_enabled_ff;
	reg [1:0]  level_ff;

	always @* begin
		grant = psw_ff[`DRS_CC_I] && (reqlvl_ff < psw_ff[`DRS_CC_IL_HI:`DRS_CC_IL_LO]);
		bank_addr = BANK_BASE + {8'h00, bank_pointer[4:0], 3'h0};
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_mirror_ff   <= `DRS_RST_16;
			bank_base_ff   <= BANK_BASE;
			irq_enabled_ff <= 1'b0;
			level_ff       <= `DRS_RST_LVL;
		end else begin
			pc_mirror_ff   <= pc_ff;
			bank_base_ff   <= bank_addr;
			irq_enabled_ff <= psw_ff[`DRS_CC_I];
			level_ff       <= psw_ff[`DRS_CC_IL_HI:`DRS_CC_IL_LO];
		end
	end

	assign program_counter       = pc_mirror_ff;
	assign bank_base_addr        = bank_base_ff;
	assign irq_enabled           = irq_enabled_ff;
	assign interrupt_level_field = level_ff;

	// ==========================================================
	// Read path
	// ==========================================================
	// The read word is picked in the setup phase and held in a flop for
	// the access phase, so read data come from a register with no wait state.
	reg [31:0] nxt_rdata;
	reg [31:0] rdata_ff;

	always @* begin
		nxt_rdata = 32'h00000000;
		if (rd_setup) begin
			if (paddr == `DRS_OFF_PC) begin
				nxt_rdata = {16'h0000, pc_ff};
			end else if (paddr == `DRS_OFF_ACC) begin
				nxt_rdata = {16'h0000, acc_ff};
			end else if (paddr == `DRS_OFF_TMP) begin
				nxt_rdata = {16'h0000, tmp_ff};
			end else if (paddr == `DRS_OFF_IDX) begin
				nxt_rdata = {16'h0000, idx_ff};
			end else if (paddr == `DRS_OFF_EXP) begin
				nxt_rdata = {16'h0000, exp_ff};
			end else if (paddr == `DRS_OFF_SP) begin
				nxt_rdata = {16'h0000, sp_ff};
			end else if (paddr == `DRS_OFF_PSW) begin
				nxt_rdata = {16'h0000, bank_pointer, condition_code_byte};
			end else if (paddr == `DRS_OFF_BANK) begin
				nxt_rdata = {16'h0000, bank_addr};
			end else if (paddr == `DRS_OFF_ALURES) begin
				nxt_rdata = {16'h0000, alures_ff};
			end else if (paddr == `DRS_OFF_IRQCHK) begin
				nxt_rdata = {29'h00000000, grant, reqlvl_ff};
			end
		end
	end

	// Outside the access phase of a read the bus shows zero.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_ff <= 32'h00000000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign prdata = rdata_ff;

	// vectors at top
	// The top address is fixed for the 64-Kbyte space; vector fetches
	// are made by the datapath from addresses just below it.
	wire [15:0] mem_top;
	assign mem_top = `DRS_MEM_TOP;

endmodule // drs_core_regs

`default_nettype wire

// >>> test/drs_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Register bank address decode of the memory side.
module drs_mem_model (
	input  wire logic [15:0] bank_base_addr,
	input  wire logic [2:0]  reg_sel,
	output logic      [15:0] reg_addr
);
	assign reg_addr = bank_base_addr + {13'h0, reg_sel};
endmodule // drs_mem_model
`default_nettype wire

// >>> test/drs_core_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module drs_chk #(parameter [15:0] BANK_BASE = 16'h0100) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [15:0] program_counter,
	input wire logic [15:0] bank_base_addr,
	input wire logic        irq_enabled,
	input wire logic [1:0]  interrupt_level_field
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire ac = psel && penable;
	wire wr = ac && pwrite;
	property p_pc; wr && paddr == 12'h000 |-> ##2 program_counter == $past(pwdata[15:0], 2); endproperty
	a_pc: assert property (p_pc) else $error("pc mirror wrong");
	property p_ie; wr && paddr == 12'h018 |-> ##2 irq_enabled == $past(pwdata[6], 2); endproperty
	a_ie: assert property (p_ie) else $error("irq enable wrong");
	property p_il; wr && paddr == 12'h018 |-> ##2 interrupt_level_field == $past(pwdata[5:4], 2); endproperty
	a_il: assert property (p_il) else $error("level wrong");
	property p_bank;
		wr && paddr == 12'h018 |-> ##2 bank_base_addr == BANK_BASE + {8'h0, $past(pwdata[12:8], 2), 3'h0};
	endproperty
	a_bank: assert property (p_bank) else $error("bank address wrong");
	property p_err; ac && paddr > 12'h028 |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("no error on unmapped");
	property p_ok; ac && paddr <= 12'h028 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
	a_ok: assert property (p_ok) else $error("error on mapped");
	property p_rd0; ac && !pwrite && pslverr |-> prdata == 32'h0; endproperty
	a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
	property p_rdpc; ac && !pwrite && paddr == 12'h000 |-> prdata == {16'h0, program_counter}; endproperty
	a_rdpc: assert property (p_rdpc) else $error("pc read wrong");
	property p_rst; $rose(presetn) |-> !irq_enabled && interrupt_level_field == 2'h3; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	c_alu: cover property (wr && paddr == 12'h020);
	c_err: cover property (pslverr);
	c_ie: cover property (irq_enabled);
endmodule // drs_chk
bind drs_core_regs drs_chk #(.BANK_BASE(BANK_BASE)) drs_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .program_counter(program_counter), .bank_base_addr(bank_base_addr),
	.irq_enabled(irq_enabled), .interrupt_level_field(interrupt_level_field));
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "drs_defs.vh"
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, re;
	logic [11:0] paddr;
	logic [31:0] pwdata, rq;
	wire  [31:0] prdata;
	wire         pready, pslverr, irq_enabled;
	wire  [15:0] program_counter, bank_base_addr, reg_addr;
	wire  [1:0]  interrupt_level_field;
	int          mismatches, checked, cyc, i;
	logic [47:0] alu [9] = '{48'h30_0f_01_00_10_b0, 48'h30_7f_01_00_80_ba, 48'h30_ff_01_00_00_b5,
		48'h30_00_01_01_ff_b9, 48'h30_80_01_01_7f_b2, 48'hb2_81_00_02_02_b3, 48'h30_01_00_03_00_35,
		48'h30_f0_0f_04_00_34, 48'h30_7e_00_05_7f_30};
	drs_core_regs drs_core_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.program_counter(program_counter), .bank_base_addr(bank_base_addr), .irq_enabled(irq_enabled),
		.interrupt_level_field(interrupt_level_field));
	drs_mem_model drs_mem_model_i (.bank_base_addr(bank_base_addr), .reg_sel(3'h7), .reg_addr(reg_addr));
	initial begin
		pclk = 0;
		forever #50 pclk = ~pclk;
	end
	// ==========
	// Bus access and checking.
	task automatic apb(input [11:0] a, input w, input [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic chk(input string nm, input [31:0] s, input [31:0] e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	// ==========
	// Tests.
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1;
		apb(`DRS_OFF_PSW, 0, 0);
		chk("psw", rq, 32'h30);
		chk("level", interrupt_level_field, 3);
		chk("bank", bank_base_addr, 16'h0100);
		$display("reset test done");
		for (i = 0; i < 6; i++) apb(4 * i, 1, 32'hffff5a31 + i);
		for (i = 0; i < 6; i++) begin
			apb(4 * i, 0, 0);
			chk("reg", rq, 32'h5a31 + i);
		end
		chk("pc", program_counter, 16'h5a31);
		apb(`DRS_OFF_PSW, 1, 32'h1f70);
		apb(`DRS_OFF_BANK, 0, 0);
		chk("bankreg", rq, 32'h01f8);
		chk("slot", reg_addr, 16'h01ff);
		chk("ie", irq_enabled, 1);
		apb(`DRS_OFF_PSW, 0, 0);
		chk("psw", rq, 32'h1f70);
		$display("register test done");
		for (i = 0; i < 9; i++) begin
			apb(`DRS_OFF_PSW, 1, alu[i][47:40]);
			apb(`DRS_OFF_ACC, 1, {8'h12, alu[i][39:32]});
			apb(`DRS_OFF_TMP, 1, {8'h34, alu[i][31:24]});
			apb(`DRS_OFF_ALUCMD, 1, alu[i][23:16]);
			apb(`DRS_OFF_ALURES, 0, 0);
			chk("res", rq, {8'h12, alu[i][15:8]});
			apb(`DRS_OFF_ACC, 0, 0);
			chk("acc", rq, {8'h12, alu[i][15:8]});
			apb(`DRS_OFF_PSW, 0, 0);
			chk("flags", rq, alu[i][7:0]);
		end
		$display("flag test done");
		for (i = 0; i < 8; i++) begin
			apb(`DRS_OFF_PSW, 1, i[2] ? 32'h60 : 32'h20);
			apb(`DRS_OFF_IRQCHK, 1, i[1:0]);
			apb(`DRS_OFF_IRQCHK, 0, 0);
			chk("grant", rq[2], i[2] && i[1:0] < 2);
		end
		$display("interrupt test done");
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(`DRS_OFF_PSW, 0, 0);
		chk("psw_rst", rq, 32'h30);
		chk("ie_rst", irq_enabled, 0);
		$display("second reset test done");
		apb(12'h030, 1, 32'h1234);
		apb(12'h030, 0, 0);
		chk("unmapped", rq, 0);
		chk("slverr", re, 1);
		$display("unmapped test done");
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
